// ### shared/tx_seq_pkg.sv
// constants and types shared by the transmitter mode sequencer
package tx_seq_pkg;

   // ************************************************************
   // clock and timing
   // ************************************************************
   localparam int unsigned CLK_PERIOD_NS = 10;
   // lock time printed as a longest time, so cycles round down
   localparam int unsigned LOCK_TIME_NS  = 1000000;
   localparam int unsigned LOCK_CYCLES   = LOCK_TIME_NS / CLK_PERIOD_NS;
   localparam int unsigned LOCK_CNT_W    = 17;

   // ************************************************************
   // synthesizer and clock driver
   // ************************************************************
   localparam logic [6:0]  CARRIER_RATIO = 7'h40;
   localparam int unsigned CLK_DIVIDE    = 4;
   localparam int unsigned DIV_CNT_W     = 1;
   localparam logic [DIV_CNT_W-1:0] DIV_HALF_LAST = 1'h1;
   localparam logic        CLK_IDLE_LEVEL = 1'b0;

   // ************************************************************
   // modes and power enables
   // ************************************************************
   typedef enum logic [1:0] {
      MODE_STANDBY,
      MODE_SETTLE,
      MODE_LOCKED
   } mode_t;

   typedef struct packed {
      logic crystal_osc;
      logic synth;
      logic clk_driver;
      logic amp_drive_on;
   } power_t;

   localparam power_t POWER_ALL_OFF = '{default: 1'b0};

endpackage : tx_seq_pkg

// ### design/clk_out_divider.sv
// divider that drives the host clock output at a quarter of the oscillator rate
`timescale 1ns/1ps
`default_nettype none

module clk_out_divider
   import tx_seq_pkg::*;
(
   // clock and reset
   input  wire logic clk_in,
   input  wire logic srst_in,
   // control
   input  wire logic run_in,
   // clock output
   output var  logic div_clk_out
);

   // ************************************************************
   // half-period counter
   // ************************************************************
   logic [DIV_CNT_W-1:0] phase_ff;
   logic                 div_clk_ff;
   wire  logic           half_done;
   wire  logic [DIV_CNT_W-1:0] nxt_phase;
   wire  logic           nxt_div_clk;

   assign half_done   = (phase_ff == DIV_HALF_LAST);
   assign nxt_phase   = (!run_in || half_done) ? '0 : DIV_CNT_W'(phase_ff + 1'b1);
   // static level while the driver is off
   assign nxt_div_clk = !run_in ? CLK_IDLE_LEVEL :
                        (half_done ? ~div_clk_ff : div_clk_ff);

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         phase_ff   <= '0;
         div_clk_ff <= CLK_IDLE_LEVEL;
      end else begin
         phase_ff   <= nxt_phase;
         div_clk_ff <= nxt_div_clk;
      end
   end

   assign div_clk_out = div_clk_ff;

endmodule // clk_out_divider

`default_nettype wire

// ### design/uhf_tx_mode_sequencer.sv
// mode and transmit-sequence control of the uhf pll transmitter
`timescale 1ns/1ps
`default_nettype none

module uhf_tx_mode_sequencer
   import tx_seq_pkg::*;
#(
   parameter int unsigned LOCK_WAIT = LOCK_CYCLES
)
(
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       srst_in,
   // host control pins
   input  wire logic       chip_en_in,
   input  wire logic       amp_en_in,
   input  wire logic       pull_closed_in,
   // power state
   output var  power_t     power_out,
   output var  logic       locked_out,
   // synthesizer
   output var  logic [6:0] carrier_ratio_out,
   output var  logic       freq_low_out,
   // clock to host
   output var  logic       clk_out
);

   // ************************************************************
   // mode decode
   // ************************************************************
   mode_t                 mode_ff;
   mode_t                 nxt_mode;
   logic [LOCK_CNT_W-1:0] lock_cnt_ff;
   power_t                power_ff;
   logic                  locked_ff;
   logic [6:0]            ratio_ff;
   logic                  freq_low_ff;

   localparam logic [LOCK_CNT_W-1:0] LOCK_LAST = LOCK_CNT_W'(LOCK_WAIT - 1);

   wire logic             lock_done;
   wire logic             active;
   wire logic             in_settle;
   wire logic             lock_run;
   wire logic             amp_req;
   wire logic             pull_req;
   wire logic             clk_run;
   wire logic [LOCK_CNT_W-1:0] nxt_lock_cnt;
   wire power_t           nxt_power;
   wire logic             nxt_locked;
   wire logic [6:0]       nxt_ratio;
   wire logic             nxt_freq_low;

   assign lock_done = (lock_cnt_ff == LOCK_LAST);
   assign in_settle = (mode_ff == MODE_SETTLE);
   // chip enable low means standby whatever the amplifier enable does
   assign active    = chip_en_in;
   // the timer only counts while settling with the chip still enabled
   assign lock_run  = in_settle & active;

   // ************************************************************
   // keying decode
   // ************************************************************
   // keying requests only count while the chip is enabled
   assign amp_req   = active & amp_en_in;
   // a closed switch only matters with the oscillator running
   assign pull_req  = active & pull_closed_in;

   // ************************************************************
   // mode sequence
   // ************************************************************
   // standby, then settle while the synthesizer locks, then locked
   always_comb begin
      nxt_mode = mode_ff;
      case (mode_ff)
         MODE_STANDBY: begin
            if (active) begin
               nxt_mode = MODE_SETTLE;
            end
         end
         MODE_SETTLE: begin
            if (!active) begin
               nxt_mode = MODE_STANDBY;
            end else if (lock_done) begin
               nxt_mode = MODE_LOCKED;
            end
         end
         MODE_LOCKED: begin
            if (!active) begin
               nxt_mode = MODE_STANDBY;
            end
         end
         default: begin
            nxt_mode = MODE_STANDBY;
         end
      endcase
   end

   // ************************************************************
   // lock timer
   // ************************************************************
   assign nxt_lock_cnt = !lock_run ? '0 :
                         (lock_done ? lock_cnt_ff :
                          LOCK_CNT_W'(lock_cnt_ff + 1'b1));

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         lock_cnt_ff <= '0;
      end else begin
         lock_cnt_ff <= nxt_lock_cnt;
      end
   end

   // ************************************************************
   // mode register
   // ************************************************************
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         mode_ff <= MODE_STANDBY;
      end else begin
         mode_ff <= nxt_mode;
      end
   end

   // ************************************************************
   // lock indication
   // ************************************************************
   // locked is registered on the same edge as the mode change
   assign nxt_locked = (nxt_mode == MODE_LOCKED);

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         locked_ff <= 1'b0;
      end else begin
         locked_ff <= nxt_locked;
      end
   end

   // ************************************************************
   // power control
   // ************************************************************
   assign nxt_power.crystal_osc  = active;
   assign nxt_power.synth        = active;
   assign nxt_power.clk_driver   = active;
   // keying follows the pin directly; the host keeps it low while settling
   assign nxt_power.amp_drive_on = amp_req;

   // ************************************************************
   // power register
   // ************************************************************
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         power_ff <= POWER_ALL_OFF;
      end else begin
         power_ff <= nxt_power;
      end
   end

   // ************************************************************
   // carrier ratio
   // ************************************************************
   // ratio only reported while the synthesizer runs
   assign nxt_ratio = active ? CARRIER_RATIO : '0;

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         ratio_ff <= '0;
      end else begin
         ratio_ff <= nxt_ratio;
      end
   end

   // ************************************************************
   // frequency keying
   // ************************************************************
   // pulling capacitor lowers the reference and so the carrier
   assign nxt_freq_low = pull_req;

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         freq_low_ff <= 1'b0;
      end else begin
         freq_low_ff <= nxt_freq_low;
      end
   end

   // ************************************************************
   // clock output
   // ************************************************************
   // the divider sees the next driver state so its clock starts with the other enables
   assign clk_run = nxt_power.clk_driver;

   clk_out_divider u_clk_div (
      .clk_in      (clk_in),
      .srst_in     (srst_in),
      .run_in      (clk_run),
      .div_clk_out (clk_out)
   );

   // ************************************************************
   // outputs
   // ************************************************************
   // every output comes straight from a register
   assign power_out         = power_ff;
   assign locked_out        = locked_ff;
   assign carrier_ratio_out = ratio_ff;
   assign freq_low_out      = freq_low_ff;

endmodule // uhf_tx_mode_sequencer

`default_nettype wire

// ### dv/uhf_tx_mode_sequencer_chk.sv
// assertions on the ports of the transmitter mode sequencer
`timescale 1ns/1ps
`default_nettype none
module seq_chk
   import tx_seq_pkg::*;
#(parameter int unsigned LOCK_WAIT = 8)
(
   input wire logic       clk_in,
   input wire logic       srst_in,
   input wire logic       chip_en_in,
   input wire logic       amp_en_in,
   input wire logic       pull_closed_in,
   input wire power_t     power_out,
   input wire logic       locked_out,
   input wire logic [6:0] carrier_ratio_out,
   input wire logic       freq_low_out,
   input wire logic       clk_out
);
   int unsigned on_ff;
   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);
   // cycles since the chip enable was first seen high
   always_ff @(posedge clk_in) on_ff <= (srst_in || !chip_en_in) ? 0 : on_ff + 1;
   stby_off_a: assert property (!chip_en_in |=>
      {power_out, freq_low_out, carrier_ratio_out} == 12'h000) else $error("standby not off");
   osc_on_a: assert property (chip_en_in |=> power_out[3:1] == 3'h7)
      else $error("oscillator chain not on");
   ratio_a: assert property (chip_en_in |=> carrier_ratio_out == CARRIER_RATIO)
      else $error("wrong carrier ratio");
   amp_follow_a: assert property (chip_en_in |=> power_out[0] == $past(amp_en_in))
      else $error("amplifier not following enable");
   lock_time_a: assert property (locked_out == (on_ff > LOCK_WAIT))
      else $error("lock at wrong time");
   clk_div_a: assert property (clk_out == on_ff[1])
      else $error("clock output wrong phase");
   freq_low_a: assert property (chip_en_in |=> freq_low_out == $past(pull_closed_in))
      else $error("frequency shift wrong");
   amp_stby_a: assert property (amp_en_in && !chip_en_in |=> !power_out[0])
      else $error("amplifier on in standby");
endmodule // seq_chk
`default_nettype wire

// ### dv/host_model.sv
// host microcontroller model driving the transmitter control pins
`timescale 1ns/1ps
`default_nettype none
module host_model #(parameter int unsigned SETTLE = 16)
(
   input  wire logic clk_in,
   output var  logic chip_en_out,
   output var  logic amp_en_out,
   output var  logic pull_closed_out
);
   initial begin
      chip_en_out = 1'b0;
      amp_en_out = 1'b0;
      pull_closed_out = 1'b0;
   end
   // settle on the internal clock with the amplifier held off
   task automatic power_up();
      @(negedge clk_in) chip_en_out = 1'b1;
      repeat (SETTLE) @(negedge clk_in);
   endtask
   task automatic key(input logic amp, input logic pull);
      @(negedge clk_in);
      amp_en_out = amp;
      pull_closed_out = pull;
   endtask
   task automatic power_down();
      key(1'b0, 1'b0);
      @(negedge clk_in) chip_en_out = 1'b0;
   endtask
endmodule // host_model
`default_nettype wire

// ### dv/tb_uhf_tx_mode_sequencer.sv
// self-checking testbench for the transmitter mode sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_uhf_tx_mode_sequencer
   import tx_seq_pkg::*;
;
   localparam int unsigned LOCK_WAIT = 8;
   logic       clk_in = 1'b0;
   logic       srst_in = 1'b1;
   logic       chip_en_in, amp_en_in, pull_closed_in;
   power_t     power_out;
   logic       locked_out, freq_low_out, clk_out;
   logic [6:0] carrier_ratio_out;
   int         bad_count = 0;
   int         check_count = 0;
   always #5 clk_in = ~clk_in;
   host_model #(.SETTLE(4 * LOCK_WAIT)) host (.clk_in, .chip_en_out(chip_en_in),
      .amp_en_out(amp_en_in), .pull_closed_out(pull_closed_in));
   uhf_tx_mode_sequencer #(.LOCK_WAIT(LOCK_WAIT)) uut (.clk_in, .srst_in, .chip_en_in,
      .amp_en_in, .pull_closed_in, .power_out, .locked_out, .carrier_ratio_out,
      .freq_low_out, .clk_out);
   task automatic chk(input string name, input logic [6:0] got, input logic [6:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic settle();
      @(posedge clk_in);
      #1;
   endtask
   task automatic t_standby();
      host.key(1'b1, 1'b1);
      repeat (3) settle();
      chk("standby power", 7'(power_out), 7'h00);
      chk("standby clock", 7'(clk_out), 7'h00);
      host.key(1'b0, 1'b0);
   endtask
   task automatic t_up();
      int n;
      host.power_up();
      settle();
      chk("locked", 7'(locked_out), 7'h01);
      chk("power", 7'(power_out), 7'h0E);
      chk("ratio", carrier_ratio_out, 7'h40);
      n = 0;
      repeat (8) begin
         settle();
         n += int'(clk_out);
      end
      chk("clock highs", 7'(n), 7'h04);
   endtask
   task automatic t_keying();
      for (int i = 1; i < 6; i++) begin
         host.key(i[0], 1'b0);
         settle();
         chk("amp", 7'(power_out.amp_drive_on), 7'(i[0]));
      end
      host.key(1'b1, 1'b1);
      settle();
      chk("shift closed", 7'(freq_low_out), 7'h01);
      host.key(1'b1, 1'b0);
      settle();
      chk("shift open", 7'(freq_low_out), 7'h00);
   endtask
   task automatic t_down();
      host.power_down();
      settle();
      chk("down", {power_out, 2'b00, locked_out}, 7'h00);
      chk("down ratio", carrier_ratio_out, 7'h00);
   endtask
   initial begin
      repeat (12) @(posedge clk_in);
      @(negedge clk_in) srst_in = 1'b0;
      t_standby();
      t_up();
      t_keying();
      t_down();
      t_up();
      t_down();
      stop_test();
   end
   initial begin
      repeat (2000) @(posedge clk_in);
      bad_count++;
      stop_test();
   end
endmodule // tb_uhf_tx_mode_sequencer
bind uhf_tx_mode_sequencer seq_chk #(.LOCK_WAIT(LOCK_WAIT)) assert_u (.clk_in, .srst_in,
   .chip_en_in, .amp_en_in, .pull_closed_in, .power_out, .locked_out,
   .carrier_ratio_out, .freq_low_out, .clk_out);
`default_nettype wire
